// ==== pkg/bridge_pkg.sv ====
// Constants for the DMA stream to Ethernet MAC checksum bridge.
// Assumes one clock for DMA links, MAC byte streams and the register bus.
package bridge_pkg;
  // FIFO depths as address widths
  localparam int TXF_AW = 12;
  localparam int CKF_AW = 9;
  localparam int RXF_AW = 12;
  localparam int RSF_AW = 9;
  // Descriptor word indexes inside the header section
  localparam logic [2:0] DESC_CTRL_IDX = 3'h3;
  localparam logic [2:0] DESC_OFFS_IDX = 3'h4;
  localparam logic [2:0] DESC_SEED_IDX = 3'h5;
  localparam int CTRL_INS_BIT = 0;
  localparam int CTRL_UDP_BIT = 1;
  // Flag positions in 36-bit frame words
  localparam int FL_SOF = 35;
  localparam int FL_EOF = 34;
  localparam int FL_REM = 32;
  // Checksum entry fields
  localparam int CK_EN_BIT = 35;
  localparam int CK_INS_LSB = 16;
  // RX status word fields
  localparam int ST_GOOD = 31;
  localparam int ST_TRUNC = 30;
  localparam int ST_LEN_LSB = 16;
  // Register byte offsets and reset values
  localparam logic [7:0] REG_OVF = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_CK_EN = 1;
endpackage : bridge_pkg

// ==== rtl/ethernet_dma_checksum_bridge.sv ====
// Transmit and receive datapath between DMA stream links and a MAC byte interface.
// Assumes DMA links, MAC and AHB-Lite register bus all run on hclk.
//
// The register addresses and register access over AHB-Lite were decided locally.
`default_nettype none
module ethernet_dma_checksum_bridge (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [31:0] tx_data,
  input  wire logic [3:0]  tx_rem,
  input  wire logic        tx_src_rdy_n,
  output logic             tx_dst_rdy_n,
  input  wire logic        tx_sof_n,
  input  wire logic        payload_start_n,
  input  wire logic        payload_end_n,
  input  wire logic        tx_eof_n,
  output logic [7:0]       mac_tx_data,
  output logic             mac_tx_valid,
  output logic             mac_tx_last,
  input  wire logic        mac_tx_ready,
  input  wire logic [7:0]  mac_rx_data,
  input  wire logic        mac_rx_valid,
  input  wire logic        mac_rx_last,
  input  wire logic        mac_rx_good,
  output logic [31:0]      rx_data,
  output logic [3:0]       rx_rem,
  output logic             rx_src_rdy_n,
  input  wire logic        rx_dst_rdy_n,
  output logic             rx_sof_n,
  output logic             rx_payload_start_n,
  output logic             rx_payload_end_n,
  output logic             rx_eof_n
);
  typedef enum logic [0:0] {TM_IDLE, TM_SEND} tm_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_DATA, RD_FOOT} rd_state_t;

  // Ones-complement stage: sum with carry in, carry out on bit 16
  function automatic logic [16:0] add16(input logic [15:0] a, input logic [15:0] b,
                                        input logic c);
    add16 = {1'b0, a} + {1'b0, b} + {16'h0000, c};
  endfunction : add16

  // Storage for the four queues
  logic [35:0] txf_mem [2**bridge_pkg::TXF_AW];
  logic [35:0] ckf_mem [2**bridge_pkg::CKF_AW];
  logic [35:0] rxf_mem [2**bridge_pkg::RXF_AW];
  logic [31:0] rsf_mem [2**bridge_pkg::RSF_AW];
  logic [bridge_pkg::TXF_AW:0] txf_wr_ff, txf_rd_ff, txf_lvl;
  logic [bridge_pkg::CKF_AW:0] ckf_wr_ff, ckf_rd_ff, ckf_lvl;
  logic [bridge_pkg::RXF_AW:0] rxf_wr_ff, rxf_rd_ff, rxf_lvl, rxf_free;
  logic [bridge_pkg::RSF_AW:0] rsf_wr_ff, rsf_rd_ff, rsf_lvl;
  logic txf_push, txf_pop, ckf_push, ckf_pop, rxf_push, rxf_pop, rsf_push, rsf_pop;
  logic [35:0] txf_din, ckf_din, rxf_din;
  logic [31:0] rsf_din;

  // Queue levels from extended pointers
  assign txf_lvl  = txf_wr_ff - txf_rd_ff;
  assign ckf_lvl  = ckf_wr_ff - ckf_rd_ff;
  assign rxf_lvl  = rxf_wr_ff - rxf_rd_ff;
  assign rsf_lvl  = rsf_wr_ff - rsf_rd_ff;
  assign rxf_free = (bridge_pkg::RXF_AW + 1)'(2**bridge_pkg::RXF_AW) - rxf_lvl;

  // Pointer updates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txf_wr_ff <= '0;
      txf_rd_ff <= '0;
      ckf_wr_ff <= '0;
      ckf_rd_ff <= '0;
      rxf_wr_ff <= '0;
      rxf_rd_ff <= '0;
      rsf_wr_ff <= '0;
      rsf_rd_ff <= '0;
    end else begin
      txf_wr_ff <= txf_wr_ff + (bridge_pkg::TXF_AW + 1)'(txf_push);
      txf_rd_ff <= txf_rd_ff + (bridge_pkg::TXF_AW + 1)'(txf_pop);
      ckf_wr_ff <= ckf_wr_ff + (bridge_pkg::CKF_AW + 1)'(ckf_push);
      ckf_rd_ff <= ckf_rd_ff + (bridge_pkg::CKF_AW + 1)'(ckf_pop);
      rxf_wr_ff <= rxf_wr_ff + (bridge_pkg::RXF_AW + 1)'(rxf_push);
      rxf_rd_ff <= rxf_rd_ff + (bridge_pkg::RXF_AW + 1)'(rxf_pop);
      rsf_wr_ff <= rsf_wr_ff + (bridge_pkg::RSF_AW + 1)'(rsf_push);
      rsf_rd_ff <= rsf_rd_ff + (bridge_pkg::RSF_AW + 1)'(rsf_pop);
    end
  end

  // Queue storage writes
  always_ff @(posedge hclk) begin
    if (txf_push) txf_mem[txf_wr_ff[bridge_pkg::TXF_AW-1:0]] <= txf_din;
    if (ckf_push) ckf_mem[ckf_wr_ff[bridge_pkg::CKF_AW-1:0]] <= ckf_din;
    if (rxf_push) rxf_mem[rxf_wr_ff[bridge_pkg::RXF_AW-1:0]] <= rxf_din;
    if (rsf_push) rsf_mem[rsf_wr_ff[bridge_pkg::RSF_AW-1:0]] <= rsf_din;
  end

  // ---------------- Register bus ----------------
  logic [1:0]  ctrl_ff;
  logic [31:0] ovf_cnt_ff;   // overflow_count_register
  logic        bwr_ff;
  logic [7:0]  baddr_ff;
  logic        trunc_ev;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bwr_ff   <= 1'b0;
      baddr_ff <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else if (hready) begin
      bwr_ff   <= hsel && htrans[1] && hwrite;
      baddr_ff <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          bridge_pkg::REG_OVF:  hrdata <= ovf_cnt_ff;
          bridge_pkg::REG_CTRL: hrdata <= {30'h0000_0000, ctrl_ff};
          bridge_pkg::REG_STAT: hrdata <= {28'h000_0000, rsf_lvl == '0, rxf_lvl == '0,
                                           ckf_lvl == '0, txf_lvl == '0};
          default:              hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register write in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_ff <= bridge_pkg::CTRL_RST;
    else if (bwr_ff && baddr_ff == bridge_pkg::REG_CTRL) ctrl_ff <= hwdata[1:0];
  end

  // Truncation counter, read only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ovf_cnt_ff <= 32'h0000_0000;
    else if (trunc_ev) ovf_cnt_ff <= ovf_cnt_ff + 32'h0000_0001;
  end

  // ---------------- TX DMA side ----------------
  logic        in_hdr_ff, in_pay_ff, pend_ff, cy_ff;
  logic [2:0]  hidx_ff, hidx;
  logic [11:0] woff_ff;
  logic [7:0]  tx_control_field_ff;
  logic [15:0] cstart_ff, cins_ff, acc_ff;
  logic        tx_beat, hdr_beat, pay_beat;
  logic [31:0] tx_m;
  logic [16:0] s1, s2, f1, f2;
  logic [15:0] ck_final;
  logic [1:0]  tx_bin;

  assign tx_dst_rdy_n = !((txf_lvl != (bridge_pkg::TXF_AW + 1)'(2**bridge_pkg::TXF_AW))
                          && (ckf_lvl != (bridge_pkg::CKF_AW + 1)'(2**bridge_pkg::CKF_AW))
                          && !pend_ff);
  assign tx_beat  = !tx_src_rdy_n && !tx_dst_rdy_n;
  assign hdr_beat = tx_beat && (!tx_sof_n || in_hdr_ff) && payload_start_n;
  assign pay_beat = tx_beat && (!payload_start_n || in_pay_ff);
  assign hidx     = !tx_sof_n ? 3'h0 : hidx_ff;

  // Byte lanes counted toward the sum
  for (genvar j = 0; j < 4; j++) begin : g_lane
    logic inc;
    assign inc = ({2'b00, woff_ff, 2'(j)} >= cstart_ff)
                 && (payload_end_n || !tx_rem[3-j]);
    assign tx_m[31-8*j -: 8] = inc ? tx_data[31-8*j -: 8] : 8'h00;
  end

  // Two chained ones-complement adders per beat
  assign s1 = add16(acc_ff, tx_m[31:16], cy_ff);
  assign s2 = add16(s1[15:0], tx_m[15:0], s1[16]);
  assign f1 = add16(acc_ff, 16'h0000, cy_ff);
  assign f2 = add16(f1[15:0], 16'h0000, f1[16]);
  assign ck_final = (tx_control_field_ff[bridge_pkg::CTRL_UDP_BIT] && f2[15:0] == 16'hFFFF)
                    ? 16'hFFFF : ~f2[15:0];
  // Valid lanes minus one from the active-low lane mask
  assign tx_bin = 2'(3'(!tx_rem[3]) + 3'(!tx_rem[2]) + 3'(!tx_rem[1]) + 3'(!tx_rem[0]) - 3'h1);

  assign txf_push = pay_beat;
  assign txf_din  = {!payload_start_n, !payload_end_n,
                     payload_end_n ? 2'b11 : tx_bin, tx_data};
  assign ckf_push = pend_ff;
  assign ckf_din  = {tx_control_field_ff[bridge_pkg::CTRL_INS_BIT] && ctrl_ff[bridge_pkg::CTRL_CK_EN],
                     3'b000, cins_ff, ck_final};

  // Stream section tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_hdr_ff <= 1'b0;
      in_pay_ff <= 1'b0;
      hidx_ff   <= 3'h0;
      woff_ff   <= 12'h000;
      pend_ff   <= 1'b0;
    end else begin
      pend_ff <= pay_beat && !payload_end_n;
      if (hdr_beat) begin
        in_hdr_ff <= 1'b1;
        hidx_ff   <= (hidx == 3'h7) ? hidx : hidx + 3'h1;
      end
      if (pay_beat) begin
        in_hdr_ff <= 1'b0;
        in_pay_ff <= payload_end_n;
        woff_ff   <= payload_end_n ? woff_ff + 12'h001 : 12'h000;
      end
    end
  end

  // Header field capture and running sum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_control_field_ff  <= 8'h00;
      cstart_ff <= 16'h0000;
      cins_ff   <= 16'h0000;
      acc_ff    <= 16'h0000;
      cy_ff     <= 1'b0;
    end else if (hdr_beat) begin
      unique case (hidx)
        bridge_pkg::DESC_CTRL_IDX: tx_control_field_ff <= tx_data[7:0];
        bridge_pkg::DESC_OFFS_IDX: {cstart_ff, cins_ff} <= tx_data;
        bridge_pkg::DESC_SEED_IDX: begin
          acc_ff <= tx_data[15:0];
          cy_ff  <= 1'b0;
        end
        default: ;
      endcase
    end else if (pay_beat) begin
      acc_ff <= s2[15:0];
      cy_ff  <= s2[16];
    end
  end

  // ---------------- TX MAC side ----------------
  tm_state_t   tm_ff;
  logic [35:0] ent_ff, tword;
  logic [15:0] boff_ff;
  logic [1:0]  tlane_ff;
  logic        tadv, tlast;
  logic [7:0]  tbyte;

  assign tadv  = !mac_tx_valid || mac_tx_ready;
  assign tword = txf_mem[txf_rd_ff[bridge_pkg::TXF_AW-1:0]];
  assign tlast = tword[bridge_pkg::FL_EOF] && tlane_ff == tword[bridge_pkg::FL_REM +: 2];
  assign ckf_pop = (tm_ff == TM_IDLE) && ckf_lvl != '0 && tadv;
  assign txf_pop = (tm_ff == TM_SEND) && tadv && (tlane_ff == 2'h3 || tlast);

  // Byte select with checksum overwrite
  always_comb begin
    tbyte = tword[8*(3-tlane_ff) +: 8];
    if (ent_ff[bridge_pkg::CK_EN_BIT]) begin
      if (boff_ff == ent_ff[bridge_pkg::CK_INS_LSB +: 16]) tbyte = ent_ff[15:8];
      if (boff_ff == ent_ff[bridge_pkg::CK_INS_LSB +: 16] + 16'h0001) tbyte = ent_ff[7:0];
    end
  end

  // Reader sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tm_ff    <= TM_IDLE;
      ent_ff   <= 36'h0_0000_0000;
      boff_ff  <= 16'h0000;
      tlane_ff <= 2'h0;
    end else begin
      unique case (tm_ff)
        TM_IDLE: if (ckf_pop) begin
          ent_ff   <= ckf_mem[ckf_rd_ff[bridge_pkg::CKF_AW-1:0]];
          boff_ff  <= 16'h0000;
          tlane_ff <= 2'h0;
          tm_ff    <= TM_SEND;
        end
        TM_SEND: if (tadv) begin
          boff_ff  <= boff_ff + 16'h0001;
          tlane_ff <= tlast ? 2'h0 : tlane_ff + 2'h1;
          if (tlast) tm_ff <= TM_IDLE;
        end
      endcase
    end
  end

  // MAC output register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_tx_valid <= 1'b0;
      mac_tx_data  <= 8'h00;
      mac_tx_last  <= 1'b0;
    end else if (tadv) begin
      mac_tx_valid <= tm_ff == TM_SEND;
      mac_tx_data  <= tbyte;
      mac_tx_last  <= tlast;
    end
  end

  // ---------------- RX MAC side ----------------
  logic [31:0] rword_ff, rcur;
  logic [1:0]  rlane_ff;
  logic [13:0] rlen_ff;
  logic [15:0] racc_ff;
  logic [16:0] rs;
  logic        rsof_ff, drop_ff, rbyte, rwr, rtrunc, rskip;

  assign rbyte = mac_rx_valid && !drop_ff;
  assign rwr   = rbyte && (rlane_ff == 2'h3 || mac_rx_last);
  assign rskip = rwr && rxf_free == '0;
  assign rtrunc = rwr && !mac_rx_last && rxf_free == (bridge_pkg::RXF_AW + 1)'(1);
  assign trunc_ev = rtrunc || (rskip && !drop_ff);
  assign rs = add16(racc_ff, rlen_ff[0] ? {8'h00, mac_rx_data} : {mac_rx_data, 8'h00}, 1'b0);

  // Current word with this byte placed
  always_comb begin
    rcur = rword_ff;
    rcur[8*(3-rlane_ff) +: 8] = mac_rx_data;
  end

  assign rxf_push = rwr && !rskip;
  assign rxf_din  = {rsof_ff, mac_rx_last || rtrunc, rlane_ff, rcur};
  assign rsf_push = rxf_push && (mac_rx_last || rtrunc);
  assign rsf_din  = {mac_rx_good && !rtrunc, rtrunc, rlen_ff + 14'h0001,
                     rs[15:0] + {15'h0000, rs[16]}};

  // Packing, running sum and truncation state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rword_ff <= 32'h0000_0000;
      rlane_ff <= 2'h0;
      rlen_ff  <= 14'h0000;
      racc_ff  <= 16'h0000;
      rsof_ff  <= 1'b1;
      drop_ff  <= 1'b0;
    end else if (mac_rx_valid && (mac_rx_last || drop_ff || rtrunc || rskip)) begin
      rword_ff <= 32'h0000_0000;
      rlane_ff <= 2'h0;
      rlen_ff  <= 14'h0000;
      racc_ff  <= 16'h0000;
      rsof_ff  <= 1'b1;
      drop_ff  <= !mac_rx_last;
    end else if (mac_rx_valid && rsof_ff && rlane_ff == 2'h0
                 && !ctrl_ff[bridge_pkg::CTRL_RX_EN]) begin
      drop_ff <= 1'b1;
    end else if (rbyte) begin
      rword_ff <= rwr ? 32'h0000_0000 : rcur;
      rlane_ff <= rlane_ff + 2'h1;
      rlen_ff  <= rlen_ff + 14'h0001;
      racc_ff  <= rs[15:0] + {15'h0000, rs[16]};
      if (rwr) rsof_ff <= 1'b0;
    end
  end

  // ---------------- RX DMA side ----------------
  rd_state_t   rd_ff;
  logic [31:0] st_ff;
  logic [35:0] rword;
  logic        oadv, fwd, oload;

  assign oadv  = rx_src_rdy_n || !rx_dst_rdy_n;
  assign fwd   = st_ff[bridge_pkg::ST_GOOD];
  assign rword = rxf_mem[rxf_rd_ff[bridge_pkg::RXF_AW-1:0]];
  assign rsf_pop = rd_ff == RD_IDLE && rsf_lvl != '0;
  assign rxf_pop = rd_ff == RD_DATA && oadv && rxf_lvl != '0;
  assign oload   = (rxf_pop && fwd) || (rd_ff == RD_FOOT && oadv);
  assign rx_payload_start_n = rx_sof_n;

  // Frame forwarding sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= RD_IDLE;
      st_ff <= 32'h0000_0000;
    end else begin
      unique case (rd_ff)
        RD_IDLE: if (rsf_pop) begin
          st_ff <= rsf_mem[rsf_rd_ff[bridge_pkg::RSF_AW-1:0]];
          rd_ff <= RD_DATA;
        end
        RD_DATA: if (rxf_pop && rword[bridge_pkg::FL_EOF]) rd_ff <= fwd ? RD_FOOT : RD_IDLE;
        RD_FOOT: if (oadv) rd_ff <= RD_IDLE;
        default: rd_ff <= RD_IDLE;
      endcase
    end
  end

  // Stream output register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_src_rdy_n <= 1'b1;
      rx_data      <= 32'h0000_0000;
      rx_rem       <= 4'h0;
      rx_sof_n     <= 1'b1;
      rx_payload_end_n     <= 1'b1;
      rx_eof_n     <= 1'b1;
    end else if (oadv) begin
      rx_src_rdy_n <= !oload;
      if (rd_ff == RD_FOOT) begin
        rx_data  <= st_ff;
        rx_rem   <= 4'h0;
        rx_sof_n <= 1'b1;
        rx_payload_end_n <= 1'b1;
        rx_eof_n <= 1'b0;
      end else begin
        rx_data  <= rword[31:0];
        rx_rem   <= rword[bridge_pkg::FL_EOF] ? 4'(4'hF >> (3'h1 + 3'(rword[33:32]))) : 4'h0;
        rx_sof_n <= !rword[bridge_pkg::FL_SOF];
        rx_payload_end_n <= !rword[bridge_pkg::FL_EOF];
        rx_eof_n <= 1'b1;
      end
    end
  end

  // ---------------- Checks ----------------
  property p_ck_frame;
    @(posedge hclk) disable iff (!hresetn) (ckf_lvl != '0) |-> (txf_lvl != '0);
  endproperty
  a_ck_frame: assert property (p_ck_frame) else $error("checksum entry without frame");
  property p_udp_nonzero;
    @(posedge hclk) disable iff (!hresetn)
      (ckf_push && tx_control_field_ff[bridge_pkg::CTRL_UDP_BIT]) |-> (ckf_din[15:0] != 16'h0000);
  endproperty
  a_udp_nonzero: assert property (p_udp_nonzero) else $error("udp zero sum queued");
  property p_pend_stall;
    @(posedge hclk) disable iff (!hresetn)
      (pay_beat && !payload_end_n) |=> (tx_dst_rdy_n && ckf_push)
                                       ##1 (ckf_wr_ff == $past(ckf_wr_ff) + 1'b1);
  endproperty
  a_pend_stall: assert property (p_pend_stall) else $error("checksum entry not queued");
  property p_insert;
    @(posedge hclk) disable iff (!hresetn)
      (tm_ff == TM_SEND && tadv && ent_ff[bridge_pkg::CK_EN_BIT]
       && boff_ff == ent_ff[bridge_pkg::CK_INS_LSB +: 16]) |=> (mac_tx_data == ent_ff[15:8]);
  endproperty
  a_insert: assert property (p_insert) else $error("checksum high byte not inserted");
  property p_trunc_eof;
    @(posedge hclk) disable iff (!hresetn)
      rtrunc |-> (rxf_push && rxf_din[bridge_pkg::FL_EOF] && !rsf_din[bridge_pkg::ST_GOOD]);
  endproperty
  a_trunc_eof: assert property (p_trunc_eof) else $error("truncation not closed bad");
  property p_trunc_count;
    @(posedge hclk) disable iff (!hresetn) trunc_ev |=> (ovf_cnt_ff == $past(ovf_cnt_ff) + 1);
  endproperty
  a_trunc_count: assert property (p_trunc_count) else $error("truncation not counted");
  property p_rs_frame;
    @(posedge hclk) disable iff (!hresetn) (rsf_lvl != '0) |-> (rxf_lvl != '0);
  endproperty
  a_rs_frame: assert property (p_rs_frame) else $error("status entry without frame");
  property p_footer;
    @(posedge hclk) disable iff (!hresetn)
      (rd_ff == RD_FOOT && oadv) |=> (!rx_eof_n && !rx_src_rdy_n && rx_data == $past(st_ff));
  endproperty
  a_footer: assert property (p_footer) else $error("footer does not carry status");
  property p_pack;
    @(posedge hclk) disable iff (!hresetn)
      (rxf_push && !rxf_din[bridge_pkg::FL_EOF]) |-> (rlane_ff == 2'h3);
  endproperty
  a_pack: assert property (p_pack) else $error("partial word written mid frame");
endmodule : ethernet_dma_checksum_bridge
`default_nettype wire

// ==== tb/mac_model.sv ====
// MAC core stand-in: takes transmit bytes with stalls, sends receive frames.
// Assumes the bridge clock; receive side has no back-pressure.
`default_nettype none
module mac_model (
  input  wire logic       hclk,
  input  wire logic [7:0] mac_tx_data,
  input  wire logic       mac_tx_valid,
  input  wire logic       mac_tx_last,
  output logic            mac_tx_ready,
  output logic [7:0]      mac_rx_data,
  output logic            mac_rx_valid,
  output logic            mac_rx_last,
  output logic            mac_rx_good
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] txq[$];
  integer     seed = 32'h1c0bea58;
  initial mac_tx_ready = 1'b0;
  initial mac_rx_data = 8'hA5;
  initial mac_rx_valid = 1'b0;
  initial mac_rx_last = 1'b0;
  initial mac_rx_good = 1'b0;
  // Byte sink, ready low one cycle in four
  always @(posedge hclk) begin
    if (mac_tx_valid && mac_tx_ready) txq.push_back({mac_tx_last, mac_tx_data});
    mac_tx_ready <= ($random(seed) & 3) != 0;
  end
  // One byte a cycle; released data shows the inverse
  task automatic send_rx(input logic [7:0] b[$], input logic good);
    for (int i = 0; i < b.size(); i++) begin
      mac_rx_data <= b[i];
      mac_rx_valid <= 1'b1;
      mac_rx_last <= (i == b.size() - 1);
      mac_rx_good <= good;
      @(posedge hclk);
    end
    mac_rx_valid <= 1'b0;
    mac_rx_last <= 1'b0;
    mac_rx_data <= ~b[b.size() - 1];
    mac_rx_good <= ~good;
    @(posedge hclk);
  endtask : send_rx
endmodule : mac_model
`default_nettype wire

// ==== tb/ethernet_dma_checksum_bridge_tb_top.sv ====
// Bench: register access, transmit checksum insertion, receive packing and truncation.
// Assumes mac_model on the MAC side and the bench acting as DMA controller.
`default_nettype none
module ethernet_dma_checksum_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tx_data = 32'h0, rx_data, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  tx_rem = 4'h0, rx_rem;
  logic        tx_src_rdy_n = 1'b1, tx_sof_n = 1'b1, payload_start_n = 1'b1;
  logic        payload_end_n = 1'b1, tx_eof_n = 1'b1, rx_dst_rdy_n = 1'b1;
  logic        hreadyout, hresp, tx_dst_rdy_n, rx_src_rdy_n, rx_sof_n, rx_payload_start_n;
  logic        rx_payload_end_n, rx_eof_n, mac_tx_valid, mac_tx_last, mac_tx_ready;
  logic        mac_rx_valid, mac_rx_last, mac_rx_good;
  logic [7:0]  mac_tx_data, mac_rx_data;
  logic [8:0]  etx[$];
  logic [7:0]  ct[4] = '{8'h01, 8'h02, 8'h03, 8'h01};
  integer      seed = 32'h1c0bea58, miscompares = 0, cmp_count = 0;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  ethernet_dma_checksum_bridge i_ethernet_dma_checksum_bridge (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .tx_data, .tx_rem, .tx_src_rdy_n, .tx_dst_rdy_n, .tx_sof_n, .payload_start_n,
    .payload_end_n, .tx_eof_n, .mac_tx_data, .mac_tx_valid, .mac_tx_last, .mac_tx_ready,
    .mac_rx_data, .mac_rx_valid, .mac_rx_last, .mac_rx_good, .rx_data, .rx_rem,
    .rx_src_rdy_n, .rx_dst_rdy_n, .rx_sof_n, .rx_payload_start_n, .rx_payload_end_n, .rx_eof_n);
  mac_model i_mac_model (.hclk, .mac_tx_data, .mac_tx_valid, .mac_tx_last, .mac_tx_ready,
    .mac_rx_data, .mac_rx_valid, .mac_rx_last, .mac_rx_good);
  // Ones-complement add with end-around carry
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = a + b;
    return s[15:0] + s[16];
  endfunction : add16
  // Word compare
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w
  // MAC byte compare, last flag on top
  task automatic chk_b(input logic [8:0] got, input logic [8:0] exp);
    chk_w({23'h0, got}, {23'h0, exp});
  endtask : chk_b
  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk_w({31'h0, hresp}, 32'h0);
  endtask : ahb
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_w(rd, exp);
  endtask : rchk
  // Transmit beat held until accepted; f = sof, sop, eop, eof
  task automatic tx_beat(input logic [31:0] d, input logic [3:0] f);
    tx_data <= d;
    {tx_sof_n, payload_start_n, payload_end_n, tx_eof_n} <= ~f;
    tx_src_rdy_n <= 1'b0;
    do @(posedge hclk); while (tx_dst_rdy_n !== 1'b0);
  endtask : tx_beat
  // Six header words, 64 payload bytes; expected MAC bytes queued in etx
  task automatic tx_frame(input int k);
    logic [31:0] w;
    logic [15:0] sum;
    logic [7:0]  b[$];
    sum = (k > 1) ? 16'hFFFF : 16'($random(seed));
    for (int i = 0; i < 3; i++) tx_beat(32'($random(seed)), (i == 0) ? 4'h8 : 4'h0);
    tx_beat({24'($random(seed)), ct[k]}, 4'h0);
    tx_beat({16'h000E, 16'h001A}, 4'h0);
    tx_beat({16'($random(seed)), sum}, 4'h0);
    for (int i = 0; i < 16; i++) begin
      w = (k > 1) ? 32'h0 : 32'($random(seed));
      for (int j = 0; j < 4; j++) b.push_back(w[31 - 8 * j -: 8]);
      tx_beat(w, (i == 0) ? 4'h4 : (i == 15) ? 4'h3 : 4'h0);
    end
    tx_src_rdy_n <= 1'b1;
    @(posedge hclk);
    for (int i = 14; i < 64; i++) sum = add16(sum, i[0] ? {8'h0, b[i]} : {b[i], 8'h0});
    sum = ~sum;
    if (ct[k][1] && sum == 16'h0) sum = 16'hFFFF;
    if (ct[k][0]) b[26] = sum[15:8];
    if (ct[k][0]) b[27] = sum[7:0];
    foreach (b[i]) etx.push_back({i == 63, b[i]});
  endtask : tx_frame
  // Collect receive beats with random stalls
  task automatic rx_get(input logic [31:0] e[$], input logic [3:0] lr);
    int i;
    i = 0;
    for (int t = 0; t < 8000 && i < e.size(); t++) begin
      @(posedge hclk);
      if (rx_src_rdy_n === 1'b0 && rx_dst_rdy_n === 1'b0) begin
        chk_w(rx_data, e[i]);
        chk_w({rx_sof_n, rx_payload_start_n, rx_payload_end_n, rx_eof_n, rx_rem},
          {i != 0, i != 0, i != e.size() - 2, i != e.size() - 1,
           (i == e.size() - 2) ? lr : 4'h0});
        i++;
      end
      rx_dst_rdy_n <= ($random(seed) & 3) == 0;
    end
    chk_w(i, e.size());
  endtask : rx_get
  // Receive n bytes; checksum, packing and footer worked out here
  task automatic rx_frame(input int n, input logic good, input logic fwd);
    logic [7:0]  b[$];
    logic [31:0] e[$];
    logic [15:0] cs;
    cs = 16'h0;
    for (int i = 0; i < n; i++) b.push_back(8'($random(seed)));
    for (int i = 0; i < n; i += 2) cs = add16(cs, {b[i], b[i + 1]});
    for (int i = 0; i < n; i += 4)
      e.push_back({b[i], b[i + 1], b[i + 2], b[i + 3]} & ~(32'hFFFF_FFFF >> (8 * (n - i))));
    e.push_back({good, 1'b0, 14'(n), cs});
    fork
      i_mac_model.send_rx(b, good);
      if (fwd) rx_get(e, 4'(4'hF >> ((n - 1) % 4 + 1)));
    join
  endtask : rx_frame
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h04, 32'h3);
    rchk(32'h08, 32'hF);
    rchk(32'h00, 32'h0);
    rchk(32'h40, 32'h0);
    for (int k = 0; k < 4; k++) tx_frame(k);
    for (int t = 0; t < 20000 && i_mac_model.txq.size() < etx.size(); t++) @(posedge hclk);
    chk_w(i_mac_model.txq.size(), etx.size());
    foreach (etx[i]) chk_b(i_mac_model.txq[i], etx[i]);
    rx_frame(64, 1'b1, 1'b1);
    rx_frame(40, 1'b0, 1'b0);
    rx_frame(62, 1'b1, 1'b1);
    ahb(1'b1, 32'h04, 32'h2);
    rx_frame(32, 1'b1, 1'b0);
    repeat (20) @(posedge hclk);
    rchk(32'h08, 32'hF);
    ahb(1'b1, 32'h04, 32'h3);
    rx_frame(16400, 1'b1, 1'b0);
    repeat (30) @(posedge hclk);
    rchk(32'h00, 32'h1);
    rx_frame(64, 1'b1, 1'b1);
    wrap_up;
  end
endmodule : ethernet_dma_checksum_bridge_tb_top
`default_nettype wire
